// [src/hpa_pkg.sv]
package hpa_pkg;

	// command byte layout
	localparam int unsigned CMD_W        = 8;
	localparam int unsigned VOL_W        = 6;
	localparam int unsigned CMD_PWR_BIT  = 7;
	localparam int unsigned CMD_BASS_BIT = 6;
	localparam logic [7:0]  CMD_RESET    = 8'hff;

	// bus addressing: two variants differ in the address lsb
	localparam logic [6:0]  ADDR_VAR_A   = 7'h4c;
	localparam logic [6:0]  ADDR_VAR_B   = 7'h4d;

	// bit counter: 8 data bits then the acknowledge clock
	localparam logic [3:0]  BIT_BYTE     = 4'h8;
	localparam logic [3:0]  BIT_ACK      = 4'h9;

	// attenuation in half-dB units
	localparam int unsigned ATTEN_W      = 8;

	typedef struct packed {
		logic             pwr_en;
		logic             bass_en;
		logic [VOL_W-1:0] volume;
	} hpa_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_IGNORE
	} hpa_state_t;

endpackage : hpa_pkg

// [src/hpa_serial_ctrl.sv]
`timescale 1ns/1ps

// Functional notes
// - hardware power-down pin low disables amplifier, outputs high-Z
// - power-enable bit zero forces power-down
// - run only with pin high and bit set
// - serial port and register live during power-down
// - bass enable routes input, else to ground
// - six-bit volume field selects 64 levels
// - serial clock up to 400 kHz
// - slave only; drives data line just for ack
// - bytes are 8 bits plus ack clock
// - data open-drain pull-low, clock input only
// - data changes with clock high are conditions
// - start: data falls; stop: data rises; clock high
// - repeated start restarts address reception
// - stop aborts anywhere, except same high as start
// - first byte: seven address bits plus read/write
// - read address acked, then never drives data
// - ack pulls data low across ninth clock high
// - frame: start, address write, one byte, stop
// - bit 7 power, bit 6 bass, 5:0 volume
// - volume monotonic from 120 dB mute to 0
// - register resets to all ones
module hpa_serial_ctrl #(
	parameter bit VARIANT_B = 1'b0
) (
	// clocks and reset
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_b_i,
	// two-wire link
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output      logic                       sda_o,
	output      logic                       sda_oe_o,
	// hardware control pin
	input  wire logic                       hw_power_down_n_i,
	// amplifier controls
	output      logic                       amp_enable_o,
	output      logic                       out_hiz_o,
	output      logic                       bass_to_amp_o,
	output      logic                       bass_to_gnd_o,
	output      logic [hpa_pkg::VOL_W-1:0]  volume_o,
	output      logic [hpa_pkg::ATTEN_W-1:0] atten_half_db_o,
	output      hpa_pkg::hpa_cmd_t          cmd_o
);
	import hpa_pkg::*;

	// volume code to attenuation in half-dB, monotonic down to zero
	function automatic logic [ATTEN_W-1:0] vol_to_atten(input logic [VOL_W-1:0] code);
		logic [ATTEN_W-1:0] c;
		c = {2'h0, code};
		if (code < 6'h0f) begin
			vol_to_atten = 8'hf0 - (c << 3);
		end else if (code < 6'h21) begin
			vol_to_atten = 8'h7c - ((c - 8'h0f) << 2);
		end else if (code < 6'h3a) begin
			vol_to_atten = 8'h36 - ((c - 8'h21) << 1);
		end else begin
			vol_to_atten = 8'h05 - (c - 8'h3a);
		end
	endfunction : vol_to_atten

	localparam logic [6:0] OWN_ADDR = VARIANT_B ? ADDR_VAR_B : ADDR_VAR_A;

	////////////////////////////////////////////////////////////////////////////
	// link domain

	logic [CMD_W-1:0] link_shift_reg;

	// samples the data line on each clock rise; the bit count lives in the
	// reference domain, which reads this word only after it has seen the
	// rise that completed it, while the clock is still high and it is stable
	always_ff @(posedge scl_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link_shift_reg <= 8'h00;
		end else begin
			link_shift_reg <= {link_shift_reg[CMD_W-2:0], sda_i};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic scl_meta, scl_s, scl_d;
	logic sda_meta, sda_s, sda_d;
	logic pd_meta, pd_s;

	// two flops per pin; only the second stage and its delay are read
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			scl_d    <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
			sda_d    <= 1'b1;
			pd_meta  <= 1'b0;
			pd_s     <= 1'b0;
		end else begin
			scl_meta <= scl_i;
			scl_s    <= scl_meta;
			scl_d    <= scl_s;
			sda_meta <= sda_i;
			sda_s    <= sda_meta;
			sda_d    <= sda_s;
			pd_meta  <= hw_power_down_n_i;
			pd_s     <= pd_meta;
		end
	end

	// clock edges, and bus conditions seen with the clock high
	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////////////////
	// frame sequencer

	hpa_state_t state_reg, next_st_reg;
	logic [3:0] bit_cnt_reg;
	logic       ack_pend_reg;
	logic       start_high_reg;
	logic       stop_taken;
	logic       byte_done;

	// a stop sharing the clock-high pulse of a start is not a stop
	assign stop_taken = stop_ev & ~start_high_reg;
	assign byte_done  = scl_rise && (bit_cnt_reg == BIT_BYTE - 4'h1);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			start_high_reg <= 1'b0;
		end else if (start_ev) begin
			start_high_reg <= 1'b1;
		end else if (scl_fall) begin
			start_high_reg <= 1'b0;
		end
	end

	// start or repeated start always reopens address reception
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg    <= ST_IDLE;
			next_st_reg  <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			ack_pend_reg <= 1'b0;
		end else if (start_ev) begin
			state_reg    <= ST_ADDR;
			bit_cnt_reg  <= 4'h0;
			ack_pend_reg <= 1'b0;
		end else if (stop_taken) begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			ack_pend_reg <= 1'b0;
		end else if (state_reg != ST_IDLE) begin
			if (scl_rise) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			if (byte_done) begin
				case (state_reg)
					ST_ADDR: begin
						// top seven bits address, lsb read flag
						if (link_shift_reg[7:1] == OWN_ADDR) begin
							ack_pend_reg <= 1'b1;
							next_st_reg  <= link_shift_reg[0] ? ST_IGNORE : ST_DATA;
						end else begin
							ack_pend_reg <= 1'b0;
							next_st_reg  <= ST_IGNORE;
						end
					end
					ST_DATA: begin
						ack_pend_reg <= 1'b1;
						next_st_reg  <= ST_IGNORE;
					end
					default: begin
						ack_pend_reg <= 1'b0;
						next_st_reg  <= ST_IGNORE;
					end
				endcase
			end
			if (scl_fall && bit_cnt_reg == BIT_ACK) begin
				bit_cnt_reg  <= 4'h0;
				ack_pend_reg <= 1'b0;
				state_reg    <= next_st_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data line driver

	logic sda_oe_reg;
	logic sda_out_reg;

	// pulled low from the fall after bit 8 to the fall after the ack clock,
	// so the line is steady over the whole ninth high; released otherwise
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sda_oe_reg  <= 1'b0;
			sda_out_reg <= 1'b0;
		end else if (start_ev || stop_taken) begin
			sda_oe_reg  <= 1'b0;
			sda_out_reg <= 1'b0;
		end else if (scl_fall && bit_cnt_reg == BIT_BYTE) begin
			sda_oe_reg  <= ack_pend_reg;
			sda_out_reg <= 1'b0;
		end else if (scl_fall && bit_cnt_reg == BIT_ACK) begin
			sda_oe_reg  <= 1'b0;
			sda_out_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command register

	hpa_cmd_t cmd_reg;

	// written only once a whole byte is in; keeps running during power-down
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_reg <= hpa_cmd_t'(CMD_RESET);
		end else if (byte_done && state_reg == ST_DATA && !start_ev && !stop_taken) begin
			cmd_reg <= hpa_cmd_t'(link_shift_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// amplifier control outputs

	logic       amp_en_reg, hiz_reg, b_amp_reg, b_gnd_reg;
	logic [VOL_W-1:0]   vol_reg;
	logic [ATTEN_W-1:0] atten_reg;
	hpa_cmd_t           cmd_out_reg;

	// output resistance stays at the shutdown value whenever not enabled
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			amp_en_reg  <= 1'b0;
			hiz_reg     <= 1'b1;
			b_amp_reg   <= 1'b0;
			b_gnd_reg   <= 1'b1;
			vol_reg     <= 6'h00;
			atten_reg   <= 8'hf0;
			cmd_out_reg <= hpa_cmd_t'(CMD_RESET);
		end else begin
			amp_en_reg  <= pd_s & cmd_reg.pwr_en;
			hiz_reg     <= ~(pd_s & cmd_reg.pwr_en);
			b_amp_reg   <= cmd_reg.bass_en;
			b_gnd_reg   <= ~cmd_reg.bass_en;
			vol_reg     <= cmd_reg.volume;
			atten_reg   <= vol_to_atten(cmd_reg.volume);
			cmd_out_reg <= cmd_reg;
		end
	end

	assign sda_o           = sda_out_reg;
	assign sda_oe_o        = sda_oe_reg;
	assign amp_enable_o    = amp_en_reg;
	assign out_hiz_o       = hiz_reg;
	assign bass_to_amp_o   = b_amp_reg;
	assign bass_to_gnd_o   = b_gnd_reg;
	assign volume_o        = vol_reg;
	assign atten_half_db_o = atten_reg;
	assign cmd_o           = cmd_out_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	pwr_gate_a: assert property (1'b1 |=> amp_enable_o == $past(pd_s & cmd_reg.pwr_en))
		else $error("amplifier enable does not follow pin and power bit");
	pd_hiz_a: assert property (!pd_s |=> out_hiz_o && !amp_enable_o)
		else $error("power-down pin low but output not high impedance");
	sw_pd_a: assert property (!cmd_reg.pwr_en |=> !amp_enable_o)
		else $error("power bit clear but amplifier enabled");
	bass_route_a: assert property (1'b1 |=> bass_to_amp_o != bass_to_gnd_o)
		else $error("bass input both routed and grounded");
	ack_hold_a: assert property (sda_oe_o && scl_rise |-> sda_oe_o [*3])
		else $error("ack released during clock high");
	ack_span_a: assert property (sda_oe_o |-> bit_cnt_reg >= BIT_BYTE)
		else $error("data line driven outside the ack bit");
	no_pull_high_a: assert property (sda_oe_o |-> !sda_o)
		else $error("data line driven high");
	partial_a: assert property ($changed(cmd_reg) |-> $past(byte_done))
		else $error("command register changed without a full byte");
	stop_abort_a: assert property (stop_taken |=> state_reg == ST_IDLE && !sda_oe_o)
		else $error("stop did not abort the frame");
	restart_a: assert property (start_ev |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
		else $error("start did not reopen address reception");
	vol_map_a: assert property (1'b1 |=> atten_half_db_o == vol_to_atten($past(cmd_reg.volume)))
		else $error("attenuation does not match volume code");

	write_cov: cover property (byte_done && state_reg == ST_DATA);
	read_ack_cov: cover property (sda_oe_o && next_st_reg == ST_IGNORE && state_reg == ST_ADDR);
	rstart_cov: cover property (start_ev && state_reg != ST_IDLE);
	nack_cov: cover property (byte_done && state_reg == ST_ADDR
		&& link_shift_reg[7:1] != OWN_ADDR);
	glitch_cov: cover property (stop_ev && start_high_reg);

endmodule : hpa_serial_ctrl

// [dv/hpa_bus_master.sv]
`timescale 1ns/1ps

// two-wire master model: drives the serial clock, open drain on data
module hpa_bus_master (
	// bus lines
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);

	// both lines released high at idle; the clock stands still between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// start or repeated start: data falls while the clock is high
	task automatic start();
		#16 sda_o = 1'b1;
		#16 scl_o = 1'b1;
		#32 sda_o = 1'b0;
		#32 scl_o = 1'b0;
	endtask : start

	// stop: data rises while the clock is high
	task automatic stop();
		#16 sda_o = 1'b0;
		#16 scl_o = 1'b1;
		#32 sda_o = 1'b1;
		#32;
	endtask : stop

	// start and stop inside one clock-high pulse; the slave must keep the frame
	task automatic start_stop();
		#16 sda_o = 1'b1;
		#16 scl_o = 1'b1;
		#16 sda_o = 1'b0;
		#16 sda_o = 1'b1;
		#32 scl_o = 1'b0;
	endtask : start_stop

	// one clock; data changes only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		#16 sda_o = b;
		#16 scl_o = 1'b1;
		#16 r = sda_i;
		#16 scl_o = 1'b0;
	endtask : bit_io

	// n bits msb first; a whole byte gets the ninth clock with data released
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] rd,
		output logic ack);
		logic r;
		rd  = 8'h00;
		ack = 1'b0;
		for (int i = 7; i > 7 - n; i--) begin
			bit_io(d[i], r);
			rd[i] = r;
		end
		if (n == 8) begin
			bit_io(1'b1, r);
			ack = !r;
		end
	endtask : xfer

endmodule : hpa_bus_master

// [dv/tb_hpa_serial_ctrl.sv]
`timescale 1ns/1ps

module tb_hpa_serial_ctrl;
	import hpa_pkg::*;

	// clock, reset and pins
	logic           ref_clk = 1'b0;
	logic           rst_b   = 1'b0;
	logic           pin     = 1'b1;
	logic           scl, sda_m, sda_w, sda_d, sda_oe;
	logic           amp_en, hiz, b_amp, b_gnd;
	logic [5:0]     vol;
	logic [7:0]     atten, exp_cmd, rd, wr;
	logic [7:0]     model_q[$];
	logic           ack_a, ack_d;
	hpa_cmd_t       cmd;
	int             failures    = 0;
	int             comparisons = 0;

	// wired-and data line with pull-up; nobody else drives the clock
	assign sda_w = sda_m & !(sda_oe & !sda_d);
	always #2 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	hpa_serial_ctrl #(.VARIANT_B(1'b0)) dut (
		.ref_clk_i(ref_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_d), .sda_oe_o(sda_oe), .hw_power_down_n_i(pin),
		.amp_enable_o(amp_en), .out_hiz_o(hiz), .bass_to_amp_o(b_amp),
		.bass_to_gnd_o(b_gnd), .volume_o(vol), .atten_half_db_o(atten), .cmd_o(cmd));
	hpa_bus_master m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));

	////////////////////////////////////////////////////////////////////////
	// attenuation in half-dB steps per volume code
	function automatic int atten_of(int c);
		if (c < 15) return 240 - 8 * c;
		if (c < 32) return 124 - 4 * (c - 15);
		if (c < 57) return 56 - 2 * (c - 32);
		return 6 - (c - 57);
	endfunction : atten_of

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// model: the register holds the byte of the last complete write frame,
	// so rejected or cut frames simply never reach the queue
	task automatic check_outs();
		logic on;
		@(negedge ref_clk);
		exp_cmd = model_q[$];
		on = pin & exp_cmd[CMD_PWR_BIT];
		check(cmd, exp_cmd);
		check(amp_en, on);
		check(hiz, !on);
		check(b_amp, exp_cmd[CMD_BASS_BIT]);
		check(b_gnd, !exp_cmd[CMD_BASS_BIT]);
		check(vol, exp_cmd[5:0]);
		check(atten, 32'(atten_of(int'(exp_cmd[5:0]))));
	endtask : check_outs

	// frames start off any clock edge: the link is unrelated in phase
	task automatic go();
		@(negedge ref_clk);
		#1.3;
		m.start();
		m.xfer({ADDR_VAR_A, 1'b0}, 8, rd, ack_a);
	endtask : go

	task automatic test_done();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////
	// watchdog well beyond the expected run length
	initial begin
		#200000;
		failures++;
		test_done();
	end

	initial begin
		void'($urandom(32'hcabf));
		model_q.push_back(CMD_RESET);
		repeat (8) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (6) @(negedge ref_clk);
		check_outs();
		// every volume code in turn, random power, bass and pin level
		for (int i = 0; i < 64; i++) begin
			@(negedge ref_clk);
			pin = 1'($urandom);
			wr  = {2'($urandom), 6'(i)};
			go();
			m.xfer(wr, 8, rd, ack_d);
			m.stop();
			model_q.push_back(wr);
			check(ack_a, 1'b1);
			check(ack_d, 1'b1);
			check_outs();
		end
		pin = 1'b1;
		// foreign address: no acknowledge, frame dropped
		@(negedge ref_clk);
		#1.3;
		m.start();
		m.xfer({ADDR_VAR_B, 1'b0}, 8, rd, ack_a);
		m.xfer(8'h15, 8, rd, ack_d);
		m.stop();
		check(ack_a, 1'b0);
		check(ack_d, 1'b0);
		check_outs();
		// read request: address acked, data line never driven
		@(negedge ref_clk);
		#1.3;
		m.start();
		m.xfer({ADDR_VAR_A, 1'b1}, 8, rd, ack_a);
		m.xfer(8'hff, 8, rd, ack_d);
		m.stop();
		check(ack_a, 1'b1);
		check(rd, 8'hff);
		check_outs();
		// stop in mid byte discards the partial byte
		go();
		m.xfer(8'h2a, 5, rd, ack_d);
		m.stop();
		check_outs();
		// repeated start mid byte, then a byte too many
		go();
		m.xfer(8'h11, 3, rd, ack_d);
		go();
		m.xfer(8'h5a, 8, rd, ack_d);
		m.xfer(8'h00, 8, rd, ack_a);
		m.stop();
		model_q.push_back(8'h5a);
		check(ack_d, 1'b1);
		check(ack_a, 1'b0);
		check_outs();
		// a stop inside the start's clock-high pulse is no stop: frame goes on
		@(negedge ref_clk);
		#1.3;
		m.start_stop();
		m.xfer({ADDR_VAR_A, 1'b0}, 8, rd, ack_a);
		m.xfer(8'hda, 8, rd, ack_d);
		m.stop();
		model_q.push_back(8'hda);
		check(ack_a, 1'b1);
		check(ack_d, 1'b1);
		check_outs();
		// pin alone powers down while the register keeps its value; the power
		// bit is set here, so only the pin can be what turns the amplifier off
		@(negedge ref_clk);
		pin = 1'b0;
		repeat (6) @(negedge ref_clk);
		check_outs();
		// writes still land while powered down
		go();
		m.xfer(8'hc5, 8, rd, ack_d);
		m.stop();
		model_q.push_back(8'hc5);
		check(ack_d, 1'b1);
		check_outs();
		test_done();
	end

endmodule : tb_hpa_serial_ctrl
